/* design/fprc_cfg.svh */
`ifndef FPRC_CFG_SVH
`define FPRC_CFG_SVH
// opcodes
`define FPRC_OP_RESUME 8'hAB
`define FPRC_OP_ULTRA 8'h79
`define FPRC_OP_PDOWN 8'hB9
`define FPRC_OP_RST_EN 8'h66
`define FPRC_OP_RST 8'h99
`define FPRC_OP_TERM 8'hF0
`define FPRC_CONFIRM 8'hD0
// clock rate
`define FPRC_CLK_MHZ 125
// delays in ns and derived cycle counts
`define FPRC_ULTRA_ENTRY_NS 3000
`define FPRC_ULTRA_RESUME_NS 10000
`define FPRC_SOFT_RESET_NS 10000
`define FPRC_ABORT_NS 10000
`define FPRC_CYC(ns) (((ns) * `FPRC_CLK_MHZ + 999) / 1000)
`define FPRC_ENTRY_CYC `FPRC_CYC(`FPRC_ULTRA_ENTRY_NS)
`define FPRC_RESUME_CYC `FPRC_CYC(`FPRC_ULTRA_RESUME_NS)
`define FPRC_RESET_CYC `FPRC_CYC(`FPRC_SOFT_RESET_NS)
`define FPRC_ABORT_CYC `FPRC_CYC(`FPRC_ABORT_NS)
`define FPRC_CNT_W 16
`endif

/* design/fprc_pkg.sv */
package fprc_pkg;
    typedef enum logic [2:0] {
        ST_STANDBY,
        ST_ENTERING,
        ST_ULTRA,
        ST_DEEP,
        ST_RESUMING,
        ST_RESETTING,
        ST_ABORTING
    } fprc_state_e;

    typedef enum logic [1:0] {
        FR_IDLE,
        FR_TERM_OP,
        FR_IGNORE
    } fprc_frame_e;
endpackage : fprc_pkg

/* design/fprc_sync.sv */
`timescale 1ns/1ns
module fprc_sync (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_async,
    input wire logic i_init,
    output logic o_level
);
    typedef struct packed {
        logic [2:0] sh;
        logic lvl;
    } fprc_sync_s;

    fprc_sync_s s_q;
    fprc_sync_s s_d;

    ////////////////////////////////////////////////////////////////
    // three stages; change counts once stages two and three agree
    always_comb begin
        s_d = s_q;
        s_d.sh = {s_q.sh[1:0], i_async};
        if (s_q.sh[1] == s_q.sh[2]) begin
            s_d.lvl = s_q.sh[2];
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            s_q <= {i_init ? 3'h7 : 3'h0, i_init};
        end else begin
            s_q <= s_d;
        end
    end

    assign o_level = s_q.lvl;
endmodule : fprc_sync

/* design/fprc_timer.sv */
`timescale 1ns/1ns
`include "fprc_cfg.svh"
module fprc_timer (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_load,
    input wire logic [`FPRC_CNT_W-1:0] i_cycles,
    output logic o_done
);
    typedef struct packed {
        logic [`FPRC_CNT_W-1:0] cnt;
        logic done;
    } fprc_timer_s;

    fprc_timer_s t_q;
    fprc_timer_s t_d;

    ////////////////////////////////////////////////////////////////
    // down counter, one-cycle done pulse at expiry
    always_comb begin
        t_d = t_q;
        t_d.done = 1'b0;
        if (i_load) begin
            t_d.cnt = i_cycles;
        end else if (t_q.cnt != '0) begin
            t_d.cnt = t_q.cnt - 1'b1;
            t_d.done = (t_q.cnt == `FPRC_CNT_W'(1));
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            t_q <= '0;
        end else begin
            t_q <= t_d;
        end
    end

    assign o_done = t_q.done;
endmodule : fprc_timer

/* design/fprc_core.sv */
`timescale 1ns/1ns
`include "fprc_cfg.svh"
module fprc_core #(
    parameter logic [`FPRC_CNT_W-1:0] ENTRY_CYC = `FPRC_CNT_W'(`FPRC_ENTRY_CYC),
    parameter logic [`FPRC_CNT_W-1:0] RESUME_CYC = `FPRC_CNT_W'(`FPRC_RESUME_CYC),
    parameter logic [`FPRC_CNT_W-1:0] RESET_CYC = `FPRC_CNT_W'(`FPRC_RESET_CYC),
    parameter logic [`FPRC_CNT_W-1:0] ABORT_CYC = `FPRC_CNT_W'(`FPRC_ABORT_CYC)
) (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_cs_n,
    input wire logic i_sclk,
    input wire logic i_si,
    input wire logic i_power_down_select,
    input wire logic i_terminate_enable,
    input wire logic i_ready_busy_flag,
    input wire logic i_write_enable_latch,
    output logic o_ultra_deep_sleep,
    output logic o_deep_sleep,
    output logic o_busy,
    output logic o_cmd_accept,
    output logic o_buffer_clear,
    output logic o_config_reset,
    output logic o_array_abort
);
    typedef struct packed {
        fprc_pkg::fprc_state_e st;
        fprc_pkg::fprc_frame_e fr;
        logic cs_n;
        logic sclk;
        logic [7:0] shift;
        logic [2:0] bits;
        logic [7:0] first;
        logic got_byte;
        logic [2:0] nbytes;
        logic rst_armed;
        logic arm_frame;
        logic resume_reset;
        logic [`FPRC_CNT_W-1:0] load_val;
        logic load;
        logic ultra;
        logic deep;
        logic busy;
        logic accept;
        logic buf_clr;
        logic cfg_rst;
        logic abort;
    } fprc_core_s;

    fprc_core_s s_q;
    fprc_core_s s_d;
    logic cs_n_s;
    logic sclk_s;
    logic si_s;
    logic tmr_done;

    ////////////////////////////////////////////////////////////////
    // pin synchronisers and delay timer
    fprc_sync u_sync_cs (
        .i_clk_sys(i_clk_sys),
        .i_rst(i_rst),
        .i_async(i_cs_n),
        .i_init(1'b1),
        .o_level(cs_n_s)
    );

    fprc_sync u_sync_sclk (
        .i_clk_sys(i_clk_sys),
        .i_rst(i_rst),
        .i_async(i_sclk),
        .i_init(1'b0),
        .o_level(sclk_s)
    );

    fprc_sync u_sync_si (
        .i_clk_sys(i_clk_sys),
        .i_rst(i_rst),
        .i_async(i_si),
        .i_init(1'b0),
        .o_level(si_s)
    );

    fprc_timer u_timer (
        .i_clk_sys(i_clk_sys),
        .i_rst(i_rst),
        .i_load(s_q.load),
        .i_cycles(s_q.load_val),
        .o_done(tmr_done)
    );

    function automatic logic heard(input fprc_pkg::fprc_state_e st, input logic [7:0] op);
        unique case (st)
            fprc_pkg::ST_STANDBY: heard = 1'b1;
            fprc_pkg::ST_ULTRA: heard = (op == `FPRC_OP_RESUME);
            fprc_pkg::ST_DEEP: heard = (op == `FPRC_OP_RESUME)
                || (op == `FPRC_OP_RST_EN) || (op == `FPRC_OP_RST);
            fprc_pkg::ST_ENTERING: heard = 1'b0;
            fprc_pkg::ST_RESUMING: heard = 1'b0;
            fprc_pkg::ST_RESETTING: heard = 1'b0;
            fprc_pkg::ST_ABORTING: heard = 1'b0;
            default: heard = 1'b0;
        endcase
    endfunction : heard

    // states that run the delay timer
    function automatic logic timed(input fprc_pkg::fprc_state_e st);
        unique case (st)
            fprc_pkg::ST_ENTERING: timed = 1'b1;
            fprc_pkg::ST_RESUMING: timed = 1'b1;
            fprc_pkg::ST_RESETTING: timed = 1'b1;
            fprc_pkg::ST_ABORTING: timed = 1'b1;
            default: timed = 1'b0;
        endcase
    endfunction : timed

    ////////////////////////////////////////////////////////////////
    // frame decode and power state machine
    always_comb begin
        logic rise_sclk;
        logic cs_rise;
        logic cs_fall;
        logic [7:0] nxt;
        logic aligned;
        rise_sclk = sclk_s && !s_q.sclk;
        cs_rise = cs_n_s && !s_q.cs_n;
        cs_fall = !cs_n_s && s_q.cs_n;
        nxt = {s_q.shift[6:0], si_s};
        aligned = s_q.got_byte && (s_q.bits == 3'h0);
        s_d = s_q;
        s_d.cs_n = cs_n_s;
        s_d.sclk = sclk_s;
        s_d.load = 1'b0;
        s_d.buf_clr = 1'b0;
        s_d.cfg_rst = 1'b0;
        s_d.abort = 1'b0;
        s_d.accept = 1'b0;
        if (cs_fall) begin
            s_d.bits = 3'h0;
            s_d.got_byte = 1'b0;
            s_d.nbytes = 3'h0;
            s_d.fr = fprc_pkg::FR_IDLE;
            s_d.arm_frame = s_q.rst_armed;
        end
        if (!cs_n_s && rise_sclk) begin
            s_d.shift = nxt;
            s_d.bits = s_q.bits + 3'h1;
            if (s_q.bits == 3'h7) begin
                s_d.got_byte = 1'b1;
                if (s_q.nbytes != 3'h7) begin
                    s_d.nbytes = s_q.nbytes + 3'h1;
                end
                if (s_q.nbytes == 3'h0) begin
                    s_d.first = nxt;
                    if (s_q.arm_frame && nxt != `FPRC_OP_RST) begin
                        s_d.rst_armed = 1'b0;
                    end
                    if (nxt == `FPRC_OP_TERM && s_q.st == fprc_pkg::ST_STANDBY) begin
                        s_d.fr = fprc_pkg::FR_TERM_OP;
                    end
                end else if (s_q.fr == fprc_pkg::FR_TERM_OP && s_q.nbytes == 3'h1) begin
                    s_d.fr = (nxt == `FPRC_CONFIRM) ? fprc_pkg::FR_TERM_OP
                        : fprc_pkg::FR_IGNORE;
                end
            end
        end
        if (cs_rise && s_q.got_byte) begin
            // command executes only on a byte-aligned rise
            if (aligned && heard(s_q.st, s_q.first)) begin
                unique case (s_q.first)
                    `FPRC_OP_RESUME: begin
                        if (s_q.nbytes == 3'h1 && (s_q.st == fprc_pkg::ST_ULTRA
                            || s_q.st == fprc_pkg::ST_DEEP)) begin
                            s_d.resume_reset = (s_q.st == fprc_pkg::ST_ULTRA);
                            s_d.buf_clr = (s_q.st == fprc_pkg::ST_ULTRA);
                            s_d.cfg_rst = (s_q.st == fprc_pkg::ST_ULTRA);
                            s_d.st = fprc_pkg::ST_RESUMING;
                            s_d.load_val = RESUME_CYC;
                            s_d.load = 1'b1;
                            s_d.accept = 1'b1;
                        end
                    end
                    `FPRC_OP_ULTRA, `FPRC_OP_PDOWN: begin
                        if (!i_ready_busy_flag) begin
                            s_d.ultra = 1'b0;
                            s_d.deep = 1'b0;
                            s_d.st = fprc_pkg::ST_ENTERING;
                            s_d.load_val = ENTRY_CYC;
                            s_d.load = 1'b1;
                            s_d.accept = 1'b1;
                            // remember target: deep only for B9h with select set
                            s_d.resume_reset = !(s_q.first == `FPRC_OP_PDOWN
                                && i_power_down_select);
                        end
                    end
                    `FPRC_OP_RST_EN: begin
                        if (s_q.nbytes == 3'h1) begin
                            s_d.rst_armed = 1'b1;
                            s_d.accept = 1'b1;
                        end
                    end
                    `FPRC_OP_RST: begin
                        if (s_q.arm_frame && s_q.rst_armed && s_q.nbytes == 3'h1) begin
                            s_d.rst_armed = 1'b0;
                            s_d.st = fprc_pkg::ST_RESETTING;
                            s_d.cfg_rst = 1'b1;
                            s_d.buf_clr = 1'b1;
                            s_d.abort = 1'b1;
                            s_d.ultra = 1'b0;
                            s_d.deep = 1'b0;
                            s_d.load_val = RESET_CYC;
                            s_d.load = 1'b1;
                            s_d.accept = 1'b1;
                        end
                    end
                    `FPRC_OP_TERM: begin
                        // write latch state plays no part
                        if (i_terminate_enable && s_q.fr == fprc_pkg::FR_TERM_OP
                            && s_q.nbytes == 3'h2) begin
                            s_d.st = fprc_pkg::ST_ABORTING;
                            s_d.abort = 1'b1;
                            s_d.load_val = ABORT_CYC;
                            s_d.load = 1'b1;
                            s_d.accept = 1'b1;
                        end
                    end
                    default: begin
                    end
                endcase
            end
            if (s_q.first != `FPRC_OP_RST_EN || !aligned) begin
                // a failed reset frame also drops the arming
                s_d.arm_frame = 1'b0;
                s_d.rst_armed = 1'b0;
            end
        end
        if (tmr_done) begin
            unique case (s_q.st)
                fprc_pkg::ST_ENTERING: begin
                    s_d.st = s_q.resume_reset ? fprc_pkg::ST_ULTRA : fprc_pkg::ST_DEEP;
                    s_d.ultra = s_q.resume_reset;
                    s_d.deep = !s_q.resume_reset;
                end
                fprc_pkg::ST_RESUMING: begin
                    s_d.st = fprc_pkg::ST_STANDBY;
                    s_d.ultra = 1'b0;
                    s_d.deep = 1'b0;
                    s_d.resume_reset = 1'b0;
                end
                fprc_pkg::ST_RESETTING, fprc_pkg::ST_ABORTING: begin
                    s_d.st = fprc_pkg::ST_STANDBY;
                end
                default: begin
                end
            endcase
        end
        s_d.busy = timed(s_d.st);
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            s_q <= '{st: fprc_pkg::ST_STANDBY, fr: fprc_pkg::FR_IDLE, cs_n: 1'b1,
                     default: '0};
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////
    // outputs straight from state
    assign o_ultra_deep_sleep = s_q.ultra;
    assign o_deep_sleep = s_q.deep;
    assign o_busy = s_q.busy;
    assign o_cmd_accept = s_q.accept;
    assign o_buffer_clear = s_q.buf_clr;
    assign o_config_reset = s_q.cfg_rst;
    assign o_array_abort = s_q.abort;
endmodule : fprc_core

/* dv/fprc_core_sva.sv */
`timescale 1ns/1ns
`include "fprc_cfg.svh"
module fprc_core_sva #(
    parameter logic [`FPRC_CNT_W-1:0] ENTRY_CYC = 16'h0014,
    parameter logic [`FPRC_CNT_W-1:0] RESUME_CYC = 16'h0014,
    parameter logic [`FPRC_CNT_W-1:0] RESET_CYC = 16'h0014,
    parameter logic [`FPRC_CNT_W-1:0] ABORT_CYC = 16'h0014
) (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_cs_n,
    input wire logic o_ultra_deep_sleep,
    input wire logic o_deep_sleep,
    input wire logic o_busy,
    input wire logic o_cmd_accept,
    input wire logic o_buffer_clear,
    input wire logic o_config_reset,
    input wire logic o_array_abort
);
    logic [`FPRC_CNT_W-1:0] busy_len_q;
    // busy run length, limit assumes reset delay is the longest
    always_ff @(posedge i_clk_sys) begin
        if (i_rst || !o_busy) begin
            busy_len_q <= '0;
        end else begin
            busy_len_q <= busy_len_q + `FPRC_CNT_W'(1);
        end
    end
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);
    ////////////////////////////////////////////////////////////
    pulse_one_a: assert property (o_cmd_accept |=> !o_cmd_accept)
        else $error("accept pulse longer than one cycle");
    clear_pair_a: assert property (o_buffer_clear |-> o_cmd_accept && !o_deep_sleep)
        else $error("buffer clear without accepted command");
    cfg_clear_a: assert property (o_config_reset == o_buffer_clear)
        else $error("config reset and buffer clear disagree");
    abort_acc_a: assert property (o_array_abort |-> o_cmd_accept && o_busy)
        else $error("array abort without accepted command");
    acc_at_rise_a: assert property (o_cmd_accept |-> i_cs_n && $past(i_cs_n, 2))
        else $error("command accepted before chip select rise");
    busy_start_a: assert property ($rose(o_busy) |-> o_cmd_accept)
        else $error("busy rose without accepted command");
    busy_refuse_a: assert property (o_busy && $past(o_busy) |-> !o_cmd_accept)
        else $error("command accepted while busy");
    sleep_excl_a: assert property (!(o_ultra_deep_sleep && o_deep_sleep))
        else $error("both sleep states at once");
    ultra_edge_a: assert property ($changed(o_ultra_deep_sleep) |-> $fell(o_busy))
        else $error("ultra sleep changed outside a delay end");
    busy_len_a: assert property (busy_len_q < RESET_CYC + `FPRC_CNT_W'(8))
        else $error("busy held too long");
endmodule : fprc_core_sva
bind fprc_core fprc_core_sva #(
    .ENTRY_CYC(ENTRY_CYC),
    .RESUME_CYC(RESUME_CYC),
    .RESET_CYC(RESET_CYC),
    .ABORT_CYC(ABORT_CYC)
) u_sva (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_cs_n(i_cs_n),
    .o_ultra_deep_sleep(o_ultra_deep_sleep),
    .o_deep_sleep(o_deep_sleep),
    .o_busy(o_busy),
    .o_cmd_accept(o_cmd_accept),
    .o_buffer_clear(o_buffer_clear),
    .o_config_reset(o_config_reset),
    .o_array_abort(o_array_abort)
);

/* dv/fprc_host.sv */
`timescale 1ns/1ns
module fprc_host (
    input wire logic i_clk_sys,
    output logic o_cs_n,
    output logic o_sclk,
    output logic o_si
);
    initial begin
        o_cs_n = 1'b1;
        o_sclk = 1'b0;
        o_si = 1'b0;
    end
    ////////////////////////////////////////////////////////////
    // msb first, 80 ns mode 0 clock only inside frames
    task automatic frame(input logic [15:0] data, input int nbits);
        for (int b = 0; b < nbits; b++) begin
            @(posedge i_clk_sys);
            o_cs_n <= 1'b0;
            o_si <= data[15-b];
            repeat (4) @(posedge i_clk_sys);
            o_sclk <= 1'b1;
            repeat (5) @(posedge i_clk_sys);
            o_sclk <= 1'b0;
        end
        repeat (5) @(posedge i_clk_sys);
        o_cs_n <= 1'b1;
        o_si <= ~o_si;
        // chip select high between frames
        repeat (12) @(posedge i_clk_sys);
    endtask : frame
endmodule : fprc_host

/* dv/tb.sv */
`timescale 1ns/1ns
module tb;
    logic clk, cs_n, sclk, si, ultra, deep, busy, acc, bclr, cfg, abrt;
    logic rst = 1'b1, pds = 1'b0, te = 1'b0, rb = 1'b0, write_enable_latch = 1'b0;
    int mismatches = 0, checked = 0, n_acc = 0, n_bc = 0, n_cr = 0, n_ab = 0;
    int b_acc, b_bc, b_cr, b_ab;

    fprc_core #(
        .ENTRY_CYC(16'h000C),
        .RESUME_CYC(16'h0014),
        .RESET_CYC(16'h0190),
        .ABORT_CYC(16'h0010)
    ) dut (
        .i_clk_sys(clk),
        .i_rst(rst),
        .i_cs_n(cs_n),
        .i_sclk(sclk),
        .i_si(si),
        .i_power_down_select(pds),
        .i_terminate_enable(te),
        .i_ready_busy_flag(rb),
        .i_write_enable_latch(write_enable_latch),
        .o_ultra_deep_sleep(ultra),
        .o_deep_sleep(deep),
        .o_busy(busy),
        .o_cmd_accept(acc),
        .o_buffer_clear(bclr),
        .o_config_reset(cfg),
        .o_array_abort(abrt)
    );
    fprc_host host (.i_clk_sys(clk), .o_cs_n(cs_n), .o_sclk(sclk), .o_si(si));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // pulse tallies
    always @(posedge clk) begin
        n_acc <= n_acc + int'(acc);
        n_bc <= n_bc + int'(bclr);
        n_cr <= n_cr + int'(cfg);
        n_ab <= n_ab + int'(abrt);
    end
    ////////////////////////////////////////////////////////////
    task automatic complete_run();
        if (mismatches == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : complete_run

    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        checked++;
        if (seen !== want) begin
            mismatches++;
            $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask : check

    task automatic lv(input logic p, input logic t, input logic r, input logic w);
        @(posedge clk);
        pds <= p;
        te <= t;
        rb <= r;
        write_enable_latch <= w;
    endtask : lv

    task automatic mark();
        @(negedge clk);
        b_acc = n_acc;
        b_bc = n_bc;
        b_cr = n_cr;
        b_ab = n_ab;
    endtask : mark

    // host waits for busy to drop before the next command
    task automatic tx(input logic [15:0] d, input int n);
        int k;
        host.frame(d, n);
        k = 0;
        @(negedge clk);
        while (busy !== 1'b0) begin
            @(negedge clk);
            k++;
            if (k > 1000) begin
                mismatches++;
                complete_run();
            end
        end
    endtask : tx

    // fields: accepts[7:6] clear cfg abort ultra deep busy
    task automatic exp(input logic [7:0] want);
        @(negedge clk);
        check({2'(n_acc - b_acc), 1'(n_bc - b_bc), 1'(n_cr - b_cr), 1'(n_ab - b_ab),
            ultra, deep, busy}, want);
    endtask : exp
    ////////////////////////////////////////////////////////////
    task automatic s_ultra();
        lv(1'b0, 1'b1, 1'b0, 1'b0);
        mark();
        tx(16'h7955, 16);
        exp(8'h44);
        mark();
        tx(16'h6600, 8);
        tx(16'hF0D0, 16);
        tx(16'hB900, 8);
        exp(8'h04);
        mark();
        tx(16'hAB00, 12);
        exp(8'h04);
        mark();
        tx(16'hAB00, 8);
        exp(8'h70);
    endtask : s_ultra

    task automatic s_abort();
        mark();
        tx(16'h7900, 7);
        tx(16'h7900, 9);
        tx(16'hF0D0, 15);
        exp(8'h00);
        lv(1'b0, 1'b1, 1'b1, 1'b0);
        mark();
        tx(16'h7900, 8);
        exp(8'h00);
        lv(1'b0, 1'b1, 1'b0, 1'b0);
        mark();
        tx(16'hB900, 8);
        exp(8'h44);
        tx(16'hAB00, 8);
    endtask : s_abort

    task automatic s_deep();
        lv(1'b1, 1'b1, 1'b0, 1'b0);
        mark();
        tx(16'hB900, 8);
        exp(8'h42);
        mark();
        tx(16'h7900, 8);
        tx(16'hF0D0, 16);
        exp(8'h02);
        mark();
        tx(16'hAB00, 8);
        exp(8'h40);
        tx(16'hB900, 8);
        tx(16'h6600, 8);
        mark();
        tx(16'h9900, 8);
        exp(8'h78);
    endtask : s_deep

    task automatic s_reset();
        lv(1'b0, 1'b1, 1'b0, 1'b0);
        mark();
        tx(16'h9900, 8);
        exp(8'h00);
        tx(16'h6600, 8);
        tx(16'h0500, 8);
        mark();
        tx(16'h9900, 8);
        exp(8'h00);
        tx(16'h6600, 8);
        tx(16'h9999, 16);
        mark();
        tx(16'h9900, 8);
        exp(8'h00);
        tx(16'h6600, 8);
        mark();
        host.frame(16'h9900, 8);
        tx(16'hF0D0, 16);
        exp(8'h78);
    endtask : s_reset

    task automatic s_term();
        lv(1'b0, 1'b0, 1'b0, 1'b0);
        mark();
        tx(16'hF0D0, 16);
        exp(8'h00);
        lv(1'b0, 1'b1, 1'b0, 1'b0);
        mark();
        tx(16'hF0D1, 16);
        tx(16'hF000, 8);
        tx(16'hD000, 8);
        exp(8'h00);
        for (int w = 0; w < 2; w++) begin
            lv(1'b0, 1'b1, 1'b1, w[0]);
            mark();
            tx(16'hF0D0, 16);
            exp(8'h48);
        end
    endtask : s_term

    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        s_ultra();
        s_abort();
        s_deep();
        s_reset();
        s_term();
        complete_run();
    end
endmodule : tb
